// ---- dv/mre_exec_tb.sv ----
// Self-checking bench for the move and rotate execution stage.
// Assumes mre_pkg is compiled first and the design answers one cycle after taking.
`timescale 1ns/100ps
module move_and_rotate_exec_tb;
  import mre_pkg::*;
  logic core_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic [7:0] reg_rdata_i = 8'h00;
  mre_wr_type reg_wr_o;
  logic [7:0] working_accumulator_o;
  logic shift_out_bit_o;
  mre_wr_type e_wr = '0;
  logic [7:0] e_acc = 8'h00;
  logic e_flag = 1'b0;
  integer num_errors = 0;
  integer compares = 0;
  integer seed = 46;
  integer cycles = 0;
  integer r;
  logic [7:0] ops [0:6] = '{8'h01, 8'h18, 8'h19, 8'h22, 8'h23, 8'h1C, 8'h00};
  logic [23:0] corner [0:5] = '{24'h1910E6, 24'h1810E6, 24'h185501, 24'h1977E6,
    24'h2344EB, 24'h0199FF};
  mre_exec mre_exec_inst (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .reg_rdata_i(reg_rdata_i),
    .reg_wr_o(reg_wr_o), .working_accumulator_o(working_accumulator_o),
    .shift_out_bit_o(shift_out_bit_o));
  // Returns write enable, address, data, accumulator and flag after one instruction.
  function automatic logic [25:0] model(logic v, logic [15:0] ins, logic [7:0] src,
    logic [7:0] acc, logic fl);
    logic [7:0] res;
    logic rot;
    logic en;
    logic nf;
    res = acc;
    rot = v && (ins[15:9] == 7'h0C || ins[15:9] == 7'h11);
    en = v && ins[15:8] == 8'h01;
    nf = fl;
    if (v && ins[15:9] == 7'h0C)
    begin
      res = {fl, src[7:1]};
      nf = src[0];
    end
    if (v && ins[15:9] == 7'h11)
      res = {src[6:0], src[7]};
    if (rot && ins[8])
      en = 1'b1;
    return {en, ins[7:0], res, (rot && !ins[8]) ? res : acc, nf};
  endfunction
  task automatic check(logic [16:0] seen, logic [16:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    forever #2 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      num_errors++;
      complete_run();
    end
  end
  initial
  begin
    repeat (20) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 407; i++)
    begin
      @(posedge core_clk_i);
      r = $random(seed);
      instr_valid_i <= (i < 6) ? 1'b1 : (i < 406 && r[1:0] != 2'b00);
      instr_i <= (i < 6) ? corner[i][23:8] : {ops[r[31:8] % 7], r[7:0]};
      reg_rdata_i <= (i < 6) ? corner[i][7:0] : r[15:8];
      @(negedge core_clk_i);
      check({16'h0000, reg_wr_o.en}, {16'h0000, e_wr.en});
      if (e_wr.en)
        check(reg_wr_o, e_wr);
      check({9'h000, working_accumulator_o}, {9'h000, e_acc});
      check({16'h0000, shift_out_bit_o}, {16'h0000, e_flag});
      {e_wr, e_acc, e_flag} = model(instr_valid_i, instr_i, reg_rdata_i, e_acc, e_flag);
    end
    complete_run();
  end
endmodule // move_and_rotate_exec_tb

// ---- hdl/mre_defs.svh ----
// Constants for the move and rotate execution datapath.
// Assumes the instruction word is 16 bits with the opcode in the upper byte.
// Notes on behaviour
// - Upper byte 0001100d selects rotate right through the shift-out flag.
// - Right rotate moves bit n to n-1, bit0 to flag, old flag to bit7.
// - Destination bit 0 sends a rotate result to the accumulator only.
// - Destination bit 1 writes a rotate result back to the addressed register.
// - Upper byte 0010001d rotates left, bit 7 wrapping to bit 0, no flags.
`ifndef MRE_DEFS_SVH
`define MRE_DEFS_SVH
`define MRE_OPC_MOVE 8'h01
`define MRE_OPC_RRC 7'h0C
`define MRE_OPC_RLN 7'h11
`define MRE_ACC_RST 8'h00
`define MRE_FLAG_RST 1'h0
`define MRE_OPC_MSB 15
`define MRE_OPC_LSB 8
`define MRE_ROT_LSB 9
`define MRE_DEST_BIT 8
`define MRE_IDX_MSB 7
`endif

// ---- hdl/mre_exec.sv ----
// Execution stage for move-accumulator, rotate left and rotate right through flag.
// Assumes the register file supplies the addressed operand in the same cycle
// and applies a one-cycle write request on the next clock edge.
`timescale 1ns/100ps
`include "mre_defs.svh"
module mre_exec
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Instruction and operand.
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [7:0] reg_rdata_i,
  // Register file write request.
  output mre_pkg::mre_wr_type reg_wr_o,
  // Architectural state.
  output logic [7:0] working_accumulator_o,
  output logic shift_out_bit_o
);
  import mre_pkg::*;

  function automatic mre_op_type decode_op(input logic [7:0] hi);
    if (hi == `MRE_OPC_MOVE)
      return MRE_MOVE;
    else if (hi[7:1] == `MRE_OPC_RRC)
      return MRE_RRC;
    else if (hi[7:1] == `MRE_OPC_RLN)
      return MRE_RLN;
    else
      return MRE_NONE;
  endfunction

  wire logic [7:0] opc_byte = instr_i[`MRE_OPC_MSB:`MRE_OPC_LSB];
  wire mre_op_type op = instr_valid_i ? decode_op(opc_byte) : MRE_NONE;
  wire logic result_target_bit = instr_i[`MRE_DEST_BIT];
  wire logic [7:0] operand_register_index = instr_i[`MRE_IDX_MSB:0];
  logic [7:0] rrc_val;
  logic rrc_flag;
  logic [7:0] rln_val;
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic flag_q;
  logic flag_d;
  mre_wr_type wr_q;
  mre_wr_type wr_d;
  logic [7:0] rot_val;

  mre_rotator u_rot
  (
    .src_i(reg_rdata_i),
    .flag_i(flag_q),
    .rrc_o(rrc_val),
    .rrc_flag_o(rrc_flag),
    .rln_o(rln_val)
  );

  assign rot_val = (op == MRE_RRC) ? rrc_val : rln_val;
  wire logic is_rot = (op == MRE_RRC) || (op == MRE_RLN);
  assign flag_d = (op == MRE_RRC) ? rrc_flag : flag_q;
  assign acc_d = (is_rot && !result_target_bit) ? rot_val : acc_q;
  wire logic wr_en = (op == MRE_MOVE) || (is_rot && result_target_bit);
  wire logic [7:0] wr_data = (op == MRE_MOVE) ? acc_q : rot_val;
  assign wr_d = '{en: wr_en, addr: operand_register_index, data: wr_data};

  // The accumulator, the flag and the write request each have a short process of their own.
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      acc_q <= `MRE_ACC_RST;
    end
    else
    begin
      acc_q <= acc_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      flag_q <= `MRE_FLAG_RST;
    end
    else
    begin
      flag_q <= flag_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
    end
  end

  assign reg_wr_o = wr_q;
  assign working_accumulator_o = acc_q;
  assign shift_out_bit_o = flag_q;

  // Fields of the instruction word, decoded again here apart from the datapath.
  wire logic [6:0] view_rot_opc = instr_i[`MRE_OPC_MSB:`MRE_ROT_LSB];
  wire logic [7:0] view_move_opc = instr_i[`MRE_OPC_MSB:`MRE_OPC_LSB];
  wire logic view_dest = instr_i[`MRE_DEST_BIT];
  wire logic [7:0] view_index = instr_i[`MRE_IDX_MSB:0];

  // All checks below run on the core clock and stand down while reset is low.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_rrc_issue;
    instr_valid_i && view_rot_opc == `MRE_OPC_RRC;
  endsequence

  sequence s_rrc_to_acc;
    instr_valid_i && view_rot_opc == `MRE_OPC_RRC && !view_dest;
  endsequence

  sequence s_rrc_to_reg;
    instr_valid_i && view_rot_opc == `MRE_OPC_RRC && view_dest;
  endsequence

  sequence s_rln_issue;
    instr_valid_i && view_rot_opc == `MRE_OPC_RLN;
  endsequence

  sequence s_rln_to_acc;
    instr_valid_i && view_rot_opc == `MRE_OPC_RLN && !view_dest;
  endsequence

  sequence s_rln_to_reg;
    instr_valid_i && view_rot_opc == `MRE_OPC_RLN && view_dest;
  endsequence

  sequence s_move_issue;
    instr_valid_i && view_move_opc == `MRE_OPC_MOVE;
  endsequence

  sequence s_other_issue;
    instr_valid_i && view_move_opc != `MRE_OPC_MOVE
      && view_rot_opc != `MRE_OPC_RRC && view_rot_opc != `MRE_OPC_RLN;
  endsequence

  sequence s_idle;
    !instr_valid_i;
  endsequence

  // Two right rotates in a row, the second reading the flag left by the first.
  sequence s_rrc_chain;
    s_rrc_to_acc ##1 s_rrc_to_acc;
  endsequence

  // A left rotate into the accumulator followed at once by a move of it.
  sequence s_rln_then_move;
    s_rln_to_acc ##1 s_move_issue;
  endsequence

  // Right rotate through the flag.
  chk_rrc_flag_takes: assert property (s_rrc_issue |=>
    shift_out_bit_o == $past(reg_rdata_i[0]))
    else $error("Right rotate did not load bit 0 into the flag.");

  chk_rrc_acc_value: assert property (s_rrc_to_acc |=>
    working_accumulator_o == {$past(shift_out_bit_o), $past(reg_rdata_i[7:1])})
    else $error("Right rotate result to accumulator is wrong.");

  chk_rrc_reg_data: assert property (s_rrc_to_reg |=> reg_wr_o.en
    && reg_wr_o.addr == $past(view_index)
    && reg_wr_o.data == {$past(shift_out_bit_o), $past(reg_rdata_i[7:1])})
    else $error("Right rotate to register wrote the wrong byte.");

  chk_rrc_acc_keep: assert property (s_rrc_to_reg |=>
    working_accumulator_o == $past(working_accumulator_o))
    else $error("Right rotate to register disturbed the accumulator.");

  chk_rrc_chain_flag: assert property (s_rrc_chain |=>
    working_accumulator_o[7] == $past(reg_rdata_i[0], 2))
    else $error("Second right rotate did not take the flag of the first.");

  // Rotate destinations and left rotate.
  chk_rot_acc_nowrite: assert property (instr_valid_i && !view_dest &&
    (view_rot_opc == `MRE_OPC_RRC || view_rot_opc == `MRE_OPC_RLN) |=> !reg_wr_o.en)
    else $error("Rotate to accumulator wrote the register file.");

  chk_rot_reg_write: assert property (s_rln_to_reg |=> reg_wr_o.en
    && reg_wr_o.addr == $past(view_index)
    && working_accumulator_o == $past(working_accumulator_o))
    else $error("Rotate to register did not write back.");

  chk_rln_value: assert property (s_rln_issue |=>
    shift_out_bit_o == $past(shift_out_bit_o)
    && (reg_wr_o.en ? reg_wr_o.data : working_accumulator_o)
    == {$past(reg_rdata_i[6:0]), $past(reg_rdata_i[7])})
    else $error("Left rotate value or flag is wrong.");

  // Move of the accumulator.
  chk_move_copy: assert property (s_move_issue |=>
    reg_wr_o.en && reg_wr_o.data == $past(working_accumulator_o)
    && shift_out_bit_o == $past(shift_out_bit_o))
    else $error("Move did not copy the accumulator.");

  chk_move_target: assert property (s_move_issue |=>
    reg_wr_o.addr == $past(view_index)
    && working_accumulator_o == $past(working_accumulator_o))
    else $error("Move wrote the wrong register or changed the accumulator.");

  chk_move_after_rln: assert property (s_rln_then_move |=>
    reg_wr_o.data == {$past(reg_rdata_i[6:0], 2), $past(reg_rdata_i[7], 2)})
    else $error("Move did not see the accumulator left by the rotate.");

  // Idle cycles and opcodes outside this block.
  chk_idle_nowrite: assert property (s_idle |=> !reg_wr_o.en)
    else $error("Write issued without an instruction.");

  chk_flag_stable: assert property (s_idle |=> $stable(shift_out_bit_o))
    else $error("Flag changed without an instruction.");

  chk_other_nop: assert property (s_other_issue |=> !reg_wr_o.en
    && $stable(working_accumulator_o) && $stable(shift_out_bit_o))
    else $error("Unknown opcode changed state or wrote a register.");
endmodule // mre_exec

// ---- hdl/mre_pkg.sv ----
// Types for the move and rotate execution datapath.
// Assumes mre_defs.svh is included by the modules that need constants.
package mre_pkg;
  typedef enum logic [1:0] {MRE_NONE, MRE_MOVE, MRE_RRC, MRE_RLN} mre_op_type;
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } mre_wr_type;
endpackage

// ---- hdl/mre_rotator.sv ----
// Combinational rotate unit for the two rotate instructions.
// Assumes the caller selects which result it uses.
`timescale 1ns/100ps
module mre_rotator
(
  // Operand and flag.
  input wire logic [7:0] src_i,
  input wire logic flag_i,
  // Results.
  output logic [7:0] rrc_o,
  output logic rrc_flag_o,
  output logic [7:0] rln_o
);
  assign rrc_o = {flag_i, src_i[7:1]};
  assign rrc_flag_o = src_i[0];
  assign rln_o = {src_i[6:0], src_i[7]};
endmodule // mre_rotator
